// ===== shared/rccr_pkg.sv
// Package for the render command and constant register bank.
`default_nettype none
package rccr_pkg;
   localparam int ADDR_W = 8;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_FLUSH = 8'h00;
   localparam logic [7:0] IDX_FILL = 8'h01;
   localparam logic [7:0] IDX_SWAP = 8'h02;
   localparam logic [7:0] IDX_FOG = 8'h03;
   localparam logic [7:0] IDX_ZA = 8'h04;
   localparam logic [7:0] IDX_KEY = 8'h05;
   localparam logic [7:0] IDX_STIP = 8'h06;
   localparam logic [7:0] IDX_C0 = 8'h07;
   localparam logic [7:0] IDX_C1 = 8'h08;
   localparam logic [7:0] IDX_PIN = 8'h09;
   localparam logic [7:0] IDX_TFAIL = 8'h0A;
   localparam logic [7:0] IDX_ZFAIL = 8'h0B;
   localparam logic [7:0] IDX_AFAIL = 8'h0C;
   localparam logic [7:0] IDX_POUT = 8'h0D;
   localparam logic [7:0] IDX_PEND = 8'h0E;
   localparam logic [7:0] IDX_MODE = 8'h0F;
   localparam logic [7:0] IDX_PATH = 8'h10;
   localparam logic [7:0] IDX_FOGCTL = 8'h11;
   localparam logic [7:0] IDX_DACTL = 8'h12;
   localparam logic [7:0] IDX_HB = 8'h13;
   localparam logic [7:0] IDX_VB = 8'h14;
   // Field positions.
   localparam int MODE_KEY_EN = 1;
   localparam int MODE_DITHER = 8;
   localparam int MODE_RGB_WR = 9;
   localparam int MODE_DEP_WR = 10;
   localparam int MODE_ZBIAS = 16;
   localparam int DA_PIPE_EN = 8;
   localparam int FOG_EN = 0;
   localparam int SWAP_SYNC = 0;
   localparam int SWAP_IV_LO = 1;
   localparam int CNT_W = 24;
   localparam int PEND_W = 3;
   localparam int PEND_LO = 28;
   localparam int COORD_W = 10;
   localparam int HI_LO = 16;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   typedef struct packed {
      logic [7:0] a;
      logic [23:0] rgb;
   } rccr_pix_s;
   typedef struct packed {
      logic [COORD_W-1:0] x;
      logic [COORD_W-1:0] y;
      logic [15:0] rgb565;
      logic [15:0] depth;
      logic wr_rgb;
      logic wr_depth;
   } rccr_fillpix_s;
endpackage
`default_nettype wire

// ===== rtl/rccr_bank.sv
// Command, constant colour and pixel statistics register bank.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module rccr_bank
   import rccr_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Host register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [ADDR_W-1:0] REG_IDX,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // Pipeline events
   input wire logic PIX_GEN,
   input wire logic PIX_PIPE_VALID,
   input wire logic PIX_DEPTH_ONLY_LFB,
   input wire logic PIX_IS_LFB,
   input wire rccr_pix_s PIX_TEX,
   input wire logic PIX_DEPTH_FAIL,
   input wire logic PIX_ALPHA_FAIL,
   input wire logic PIX_DRAWN,
   input wire logic VRETRACE,
   // Pipeline controls and constants
   output logic PIPE_FLUSH,
   output logic BUF_SWAP,
   output logic PIX_KEY_DROP,
   output rccr_pix_s PIX_SRC,
   output logic [23:0] FOG_RGB,
   output logic FOG_ACTIVE,
   output logic [15:0] BIAS_DEPTH,
   output logic [7:0] CONST_ALPHA,
   output rccr_pix_s COMB_LOCAL,
   output logic [23:0] COMB_OTHER_RGB,
   output logic [7:0] COMB_OTHER_A,
   // Fill pixel stream
   output logic FILL_VALID,
   output rccr_fillpix_s FILL_PIX,
   output logic FILL_BUSY
);
   logic [31:0] fog_q, za_q, key_q, stip_q, c0_q, c1_q, mode_q, path_q, fogctl_q, dactl_q;
   logic [31:0] hb_q, vb_q;
   logic [CNT_W-1:0] cnt_q [5];
   logic [PEND_W-1:0] pend_q;
   logic [7:0] rt_cnt_q, swap_iv_q;
   logic swap_sync_q, swap_wait_q, clr_cnt;
   logic [COORD_W-1:0] fx_q, fy_q;
   logic [1:0] dith_q;
   logic do_swap, key_hit, fill_start, swap_wr;
   rccr_pix_s src_sel;
   logic [4:0] cnt_inc;

   //////////////////////////////////////////////////////////////////////////////
   // Register writes.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         fog_q <= RESET_WORD;
         za_q <= RESET_WORD;
         key_q <= RESET_WORD;
         stip_q <= RESET_WORD;
         c0_q <= RESET_WORD;
         c1_q <= RESET_WORD;
         mode_q <= RESET_WORD;
         path_q <= RESET_WORD;
         fogctl_q <= RESET_WORD;
         dactl_q <= RESET_WORD;
         hb_q <= RESET_WORD;
         vb_q <= RESET_WORD;
      end else if (REG_WR) begin
         unique case (REG_IDX)
            IDX_FOG: fog_q <= REG_WDATA;
            IDX_ZA: za_q <= REG_WDATA;
            IDX_KEY: key_q <= REG_WDATA;
            IDX_STIP: stip_q <= REG_WDATA;
            IDX_C0: c0_q <= REG_WDATA;
            IDX_C1: c1_q <= REG_WDATA;
            IDX_MODE: mode_q <= REG_WDATA;
            IDX_PATH: path_q <= REG_WDATA;
            IDX_FOGCTL: fogctl_q <= REG_WDATA;
            IDX_DACTL: dactl_q <= REG_WDATA;
            IDX_HB: hb_q <= REG_WDATA;
            IDX_VB: vb_q <= REG_WDATA;
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read mux; counters read zero above bit 23.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= RESET_WORD;
      end else if (REG_RD) begin
         unique case (REG_IDX)
            IDX_FOG: REG_RDATA <= fog_q;
            IDX_ZA: REG_RDATA <= za_q;
            IDX_KEY: REG_RDATA <= key_q;
            IDX_STIP: REG_RDATA <= stip_q;
            IDX_C0: REG_RDATA <= c0_q;
            IDX_C1: REG_RDATA <= c1_q;
            IDX_PIN: REG_RDATA <= {8'h00, cnt_q[0]};
            IDX_TFAIL: REG_RDATA <= {8'h00, cnt_q[1]};
            IDX_ZFAIL: REG_RDATA <= {8'h00, cnt_q[2]};
            IDX_AFAIL: REG_RDATA <= {8'h00, cnt_q[3]};
            IDX_POUT: REG_RDATA <= {8'h00, cnt_q[4]};
            IDX_PEND: REG_RDATA <= {1'b0, pend_q, 28'h000_0000};
            IDX_MODE: REG_RDATA <= mode_q;
            IDX_PATH: REG_RDATA <= path_q;
            IDX_FOGCTL: REG_RDATA <= fogctl_q;
            IDX_DACTL: REG_RDATA <= dactl_q;
            IDX_HB: REG_RDATA <= hb_q;
            IDX_VB: REG_RDATA <= vb_q;
            default: REG_RDATA <= RESET_WORD;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Flush command and statistics counters.
   assign clr_cnt = REG_WR && REG_IDX == IDX_FLUSH && REG_WDATA[0];
   assign key_hit = mode_q[MODE_KEY_EN] && (src_sel.rgb == key_q[23:0]);
   assign cnt_inc = {PIX_DRAWN || (FILL_VALID && FILL_PIX.wr_rgb) || FILL_VALID,
                     PIX_ALPHA_FAIL,
                     PIX_DEPTH_FAIL,
                     PIX_PIPE_VALID && key_hit,
                     PIX_GEN};

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PIPE_FLUSH <= 1'b0;
      end else begin
         PIPE_FLUSH <= REG_WR && REG_IDX == IDX_FLUSH;
      end
   end

   // A clearing flush beats an increment in the same cycle, so a cleared counter
   // reads zero at once and never starts the next run at one.
   for (genvar i = 0; i < 5; i++) begin : g_cnt
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            cnt_q[i] <= '0;
         end else if (clr_cnt) begin
            cnt_q[i] <= '0;
         end else if (cnt_inc[i]) begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Transparent test on post-texture colour, ahead of lighting and fog.
   always_comb begin
      src_sel = PIX_TEX;
      if (PIX_IS_LFB && PIX_DEPTH_ONLY_LFB && dactl_q[DA_PIPE_EN]) begin
         src_sel = {za_q[31:24], c1_q[23:0]};
      end
   end

   // The selected colour leaves through a flop; the key test uses the live selection.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PIX_SRC <= '0;
      end else begin
         PIX_SRC <= src_sel;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PIX_KEY_DROP <= 1'b0;
      end else begin
         PIX_KEY_DROP <= PIX_PIPE_VALID && key_hit;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Constant outputs to combiners, fog and depth bias.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FOG_RGB <= '0;
         FOG_ACTIVE <= 1'b0;
         BIAS_DEPTH <= '0;
         CONST_ALPHA <= '0;
         COMB_LOCAL <= '0;
         COMB_OTHER_RGB <= '0;
         COMB_OTHER_A <= '0;
      end else begin
         FOG_ACTIVE <= fogctl_q[FOG_EN];
         FOG_RGB <= fogctl_q[FOG_EN] ? {fog_q[23:16], fog_q[15:8], fog_q[7:0]} : '0;
         BIAS_DEPTH <= mode_q[MODE_ZBIAS] ? za_q[15:0] : '0;
         CONST_ALPHA <= za_q[31:24];
         COMB_LOCAL <= c0_q;
         COMB_OTHER_RGB <= (path_q[1:0] == 2'd2) ? c1_q[23:0] : src_sel.rgb;
         COMB_OTHER_A <= (path_q[3:2] == 2'd2) ? c1_q[31:24] : src_sel.a;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Fill walker. Bounds are sampled live, so the host must not rewrite them
   // mid-fill; this saves a shadow copy.
   assign fill_start = REG_WR && REG_IDX == IDX_FILL && !FILL_BUSY;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FILL_BUSY <= 1'b0;
         FILL_VALID <= 1'b0;
         FILL_PIX <= '0;
         fx_q <= '0;
         fy_q <= '0;
      end else if (fill_start) begin
         FILL_BUSY <= (hb_q[HI_LO+:COORD_W] < hb_q[COORD_W-1:0])
                   && (vb_q[HI_LO+:COORD_W] < vb_q[COORD_W-1:0]);
         fx_q <= hb_q[HI_LO+:COORD_W];
         fy_q <= vb_q[HI_LO+:COORD_W];
         FILL_VALID <= 1'b0;
      end else if (FILL_BUSY) begin
         FILL_VALID <= 1'b1;
         FILL_PIX.x <= fx_q;
         FILL_PIX.y <= fy_q;
         FILL_PIX.depth <= za_q[15:0];
         FILL_PIX.wr_rgb <= !mode_q[MODE_RGB_WR];
         FILL_PIX.wr_depth <= !mode_q[MODE_DEP_WR];
         FILL_PIX.rgb565 <= mode_q[MODE_DITHER] ?
            {sat5(c1_q[23:16], dith_q), sat6(c1_q[15:8], dith_q), sat5(c1_q[7:0], dith_q)} :
            {c1_q[23:19], c1_q[15:10], c1_q[7:3]};
         if (fx_q + 1'b1 >= hb_q[COORD_W-1:0]) begin
            fx_q <= hb_q[HI_LO+:COORD_W];
            fy_q <= fy_q + 1'b1;
            if (fy_q + 1'b1 >= vb_q[COORD_W-1:0]) begin
               FILL_BUSY <= 1'b0;
            end
         end else begin
            fx_q <= fx_q + 1'b1;
         end
      end else begin
         FILL_VALID <= 1'b0;
      end
   end
   assign dith_q = {fx_q[0] ^ fy_q[0], fy_q[0]};

   // Ordered 2x2 dither adds a small offset before truncation, saturating.
   function automatic logic [4:0] sat5(input logic [7:0] v, input logic [1:0] d);
      logic [8:0] s;
      s = {1'b0, v} + {6'h00, d, 1'b0};
      return s[8] ? 5'h1F : s[7:3];
   endfunction
   function automatic logic [5:0] sat6(input logic [7:0] v, input logic [1:0] d);
      logic [8:0] s;
      s = {1'b0, v} + {7'h00, d};
      return s[8] ? 6'h3F : s[7:2];
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Swap command, retrace counting and pending count. One swap is held at a
   // time; a second swap written while one waits bumps the pending count and replaces
   // the held sync and interval, a deliberate simplification for lack of a command queue.
   assign swap_wr = REG_WR && REG_IDX == IDX_SWAP;
   // Only retraces before this one count toward the interval, so an interval of zero swaps at the
   // very next retrace instead of wasting a frame.
   assign do_swap = swap_wait_q && (!swap_sync_q
                    || (VRETRACE && rt_cnt_q >= swap_iv_q));
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         swap_wait_q <= 1'b0;
         swap_sync_q <= 1'b0;
         swap_iv_q <= '0;
         rt_cnt_q <= '0;
         BUF_SWAP <= 1'b0;
      end else begin
         BUF_SWAP <= do_swap;
         if (swap_wr) begin
            swap_wait_q <= 1'b1;
            swap_sync_q <= REG_WDATA[SWAP_SYNC];
            swap_iv_q <= REG_WDATA[SWAP_SYNC] ? REG_WDATA[SWAP_IV_LO+:8] : '0;
         end else if (do_swap) begin
            swap_wait_q <= 1'b0;
         end
         if (do_swap) begin
            rt_cnt_q <= '0;
         end else if (VRETRACE && rt_cnt_q != 8'hFF) begin
            rt_cnt_q <= rt_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_q <= '0;
      end else if (swap_wr && !do_swap) begin
         pend_q <= pend_q + 1'b1;
      end else if (do_swap && !swap_wr && pend_q != '0) begin
         pend_q <= pend_q - 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Assertions.
   // Counter checks compare against the previous count, so they also cover the wrap.
   a_flush_clears: assert property (@(posedge CLK) disable iff (!RST_N)
      clr_cnt |=> cnt_q[0] == '0 && cnt_q[4] == '0) else $error("counters not cleared");
   a_flush_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_IDX == IDX_FLUSH) |=> PIPE_FLUSH) else $error("no flush pulse");
   a_flush_keep: assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_IDX == IDX_FLUSH && !REG_WDATA[0] && !cnt_inc[2]) |=> $stable(cnt_q[2]))
      else $error("counter changed by flush");
   a_key_drop: assert property (@(posedge CLK) disable iff (!RST_N)
      PIX_KEY_DROP |-> $past(mode_q[MODE_KEY_EN])) else $error("drop while disabled");
   a_swap_nosync: assert property (@(posedge CLK) disable iff (!RST_N)
      (swap_wr && !REG_WDATA[SWAP_SYNC]) |=> ##1 BUF_SWAP) else $error("late async swap");
   a_swap_sync: assert property (@(posedge CLK) disable iff (!RST_N)
      (BUF_SWAP && $past(swap_sync_q)) |-> $past(VRETRACE)) else $error("sync swap off retrace");
   a_rt_clear: assert property (@(posedge CLK) disable iff (!RST_N)
      do_swap |=> rt_cnt_q == '0) else $error("retrace count kept");
   a_pend_up: assert property (@(posedge CLK) disable iff (!RST_N)
      (swap_wr && !do_swap && pend_q != '1) |=> pend_q == PEND_W'($past(pend_q) + 1'b1))
      else $error("pending count not raised");
   a_fill_depth: assert property (@(posedge CLK) disable iff (!RST_N)
      FILL_VALID |-> FILL_PIX.depth == $past(za_q[15:0])) else $error("fill depth wrong");
   a_fill_edges: assert property (@(posedge CLK) disable iff (!RST_N)
      FILL_VALID |-> FILL_PIX.x < hb_q[COORD_W-1:0]) else $error("fill past right");
   a_fill_inside: assert property (@(posedge CLK) disable iff (!RST_N)
      FILL_VALID |-> FILL_PIX.x >= hb_q[HI_LO+:COORD_W] && FILL_PIX.y >= vb_q[HI_LO+:COORD_W]
      && FILL_PIX.y < vb_q[COORD_W-1:0]) else $error("fill outside bounds");
   a_fill_trunc: assert property (@(posedge CLK) disable iff (!RST_N)
      (FILL_VALID && !$past(mode_q[MODE_DITHER])) |-> FILL_PIX.rgb565 ==
      {$past(c1_q[23:19]), $past(c1_q[15:10]), $past(c1_q[7:3])}) else $error("fill colour wrong");
   a_fog_gate: assert property (@(posedge CLK) disable iff (!RST_N)
      FOG_ACTIVE |-> FOG_RGB == $past(fog_q[23:0])) else $error("fog colour wrong");
   a_bias_const: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(mode_q[MODE_ZBIAS]) |-> BIAS_DEPTH == $past(za_q[15:0])) else $error("bias depth wrong");
   a_local_const: assert property (@(posedge CLK) disable iff (!RST_N)
      COMB_LOCAL == $past(c0_q)) else $error("local constant wrong");
   a_other_const: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(path_q[1:0]) == 2'd2 |-> COMB_OTHER_RGB == $past(c1_q[23:0])) else $error("other rgb");
   a_src_lfb: assert property (@(posedge CLK) disable iff (!RST_N)
      (PIX_IS_LFB && PIX_DEPTH_ONLY_LFB && dactl_q[DA_PIPE_EN]) |=> PIX_SRC.rgb == $past(c1_q[23:0]))
      else $error("direct colour wrong");
   a_gen_count: assert property (@(posedge CLK) disable iff (!RST_N)
      (PIX_GEN && !clr_cnt) |=> cnt_q[0] == CNT_W'($past(cnt_q[0]) + 1'b1)) else $error("no count");
   a_key_count: assert property (@(posedge CLK) disable iff (!RST_N)
      (PIX_PIPE_VALID && key_hit && !clr_cnt) |=> cnt_q[1] == CNT_W'($past(cnt_q[1]) + 1'b1))
      else $error("key fail not counted");
   a_afail_count: assert property (@(posedge CLK) disable iff (!RST_N)
      (PIX_ALPHA_FAIL && !clr_cnt) |=> cnt_q[3] == CNT_W'($past(cnt_q[3]) + 1'b1))
      else $error("alpha fail not counted");
   a_drawn_count: assert property (@(posedge CLK) disable iff (!RST_N)
      ((PIX_DRAWN || FILL_VALID) && !clr_cnt) |=> cnt_q[4] == CNT_W'($past(cnt_q[4]) + 1'b1))
      else $error("drawn pixel not counted");
   a_cnt_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
      (cnt_q[0] == '1 && PIX_GEN && !clr_cnt) |=> cnt_q[0] == '0) else $error("no wrap");
endmodule
`default_nettype wire

// ===== verif/rccr_host.sv
// Host model that reaches the bank through its register port.
`default_nettype none
module rccr_host
   import rccr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [ADDR_W-1:0] reg_idx,
   output logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_idx = '0;
      reg_wdata = 32'h0000_0000;
   end
   ////////////////////////////////////////////////////////////
   // Callers load both bounds before a fill and keep sync with interval zero when
   // triple buffering; the model only keeps each strobe one cycle wide.
   task automatic wr(input logic [ADDR_W-1:0] idx, input logic [31:0] data);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_idx <= idx;
      reg_wdata <= data;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] idx, output logic [31:0] data);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_idx <= idx;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      data = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== verif/rccr_bank_tb_top.sv
// Self-checking bench for the command, constant and counter register bank.
`default_nettype none
module rccr_bank_tb_top
   import rccr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] C1 = 32'h40F8_FC08;
   localparam logic [31:0] ZA = 32'hAB00_1357;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, pix_gen, pix_valid, pix_donly, pix_lfb, pix_dfail, pix_afail;
   logic pix_drawn, vretrace, pipe_flush, buf_swap, key_drop, fog_active, fill_valid, fill_busy;
   logic [ADDR_W-1:0] reg_idx;
   logic [31:0] reg_wdata, reg_rdata, rd_v;
   logic [23:0] fog_rgb, other_rgb;
   logic [15:0] bias_depth;
   logic [7:0] const_alpha, other_a;
   rccr_pix_s pix_tex, pix_src, comb_local;
   rccr_fillpix_s fill_pix;
   int fail_count = 0;
   int compares = 0;
   int c;
   logic [7:0] r_idx [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
      8'h3F};
   logic [31:0] r_wd [10] = '{32'h0012_3456, ZA, 32'h0055_AA33, 32'hDEAD_BEEF, 32'h8011_2233,
      C1, 32'h00FF_FFFF, 32'h0000_0005, 32'h0000_0007, 32'h1234_5678};
   logic [31:0] r_ex [10] = '{32'h0012_3456, ZA, 32'h0055_AA33, 32'hDEAD_BEEF, 32'h8011_2233,
      C1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   always #25 clk = ~clk;
   rccr_host i_rccr_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   rccr_bank i_rccr_bank (.CLK(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_IDX(reg_idx), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PIX_GEN(pix_gen),
      .PIX_PIPE_VALID(pix_valid), .PIX_DEPTH_ONLY_LFB(pix_donly), .PIX_IS_LFB(pix_lfb),
      .PIX_TEX(pix_tex), .PIX_DEPTH_FAIL(pix_dfail), .PIX_ALPHA_FAIL(pix_afail),
      .PIX_DRAWN(pix_drawn), .VRETRACE(vretrace), .PIPE_FLUSH(pipe_flush), .BUF_SWAP(buf_swap),
      .PIX_KEY_DROP(key_drop), .PIX_SRC(pix_src), .FOG_RGB(fog_rgb), .FOG_ACTIVE(fog_active),
      .BIAS_DEPTH(bias_depth), .CONST_ALPHA(const_alpha), .COMB_LOCAL(comb_local),
      .COMB_OTHER_RGB(other_rgb), .COMB_OTHER_A(other_a), .FILL_VALID(fill_valid),
      .FILL_PIX(fill_pix), .FILL_BUSY(fill_busy));
   ////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pix(input rccr_fillpix_s got, input rccr_fillpix_s exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      i_rccr_host.rd(idx, rd_v);
      chk(rd_v, exp);
   endtask
   // Event pulses, one bit per counted event except the key fail, and the retrace at the bottom.
   task automatic ev(input int n, input logic [4:0] sel);
      @(posedge clk);
      {pix_gen, pix_dfail, pix_afail, pix_drawn, vretrace} <= sel;
      repeat (n) @(posedge clk);
      {pix_gen, pix_dfail, pix_afail, pix_drawn, vretrace} <= 5'h00;
   endtask
   // Sampling starts 1 ns into the cycle of the call, before the next edge, so a swap showing there is not missed.
   task automatic sw(input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         #1;
         if (buf_swap === 1'b1) cnt++;
         @(posedge clk);
      end
   endtask
   task automatic fill(input logic [31:0] mode, input logic [31:0] hb, input int n_exp);
      int n;
      rccr_fillpix_s e;
      n = 0;
      i_rccr_host.wr(IDX_MODE, mode);
      i_rccr_host.wr(IDX_HB, hb);
      i_rccr_host.wr(IDX_FILL, 32'h0000_0000);
      #1;
      if (n_exp > 0) chk(32'(fill_busy), 32'h0000_0001);
      repeat (16) begin
         @(posedge clk);
         #1;
         if (fill_valid === 1'b1) begin
            e.x = COORD_W'(2 + n % 2);
            e.y = COORD_W'(1 + n / 2);
            e.rgb565 = {C1[23:19], C1[15:10], C1[7:3]};
            e.depth = ZA[15:0];
            e.wr_rgb = !mode[MODE_RGB_WR];
            e.wr_depth = !mode[MODE_DEP_WR];
            chk_pix(fill_pix, e);
            n++;
         end
      end
      chk(32'(n), 32'(n_exp));
      chk(32'(fill_busy), 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {pix_gen, pix_valid, pix_donly, pix_lfb, pix_dfail, pix_afail, pix_drawn} = 7'h00;
      vretrace = 1'b0;
      pix_tex = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         i_rccr_host.wr(r_idx[i], r_wd[i]);
         rdchk(r_idx[i], r_ex[i]);
      end
      chk(32'(fog_rgb), 32'h0000_0000);
      chk(32'(fog_active), 32'h0000_0000);
      i_rccr_host.wr(IDX_FOGCTL, 32'h0000_0001);
      i_rccr_host.wr(IDX_PATH, 32'h0000_000A);
      i_rccr_host.wr(IDX_DACTL, 32'h0000_0100);
      @(posedge clk);
      pix_donly <= 1'b1;
      pix_lfb <= 1'b1;
      #1;
      chk(32'(fog_active), 32'h0000_0001);
      chk(32'(fog_rgb), 32'h0012_3456);
      chk({bias_depth, const_alpha, 8'h00}, {16'h0000, ZA[31:24], 8'h00});
      chk(comb_local, 32'h8011_2233);
      chk({other_a, other_rgb}, C1);
      @(posedge clk);
      pix_donly <= 1'b0;
      pix_lfb <= 1'b0;
      #1;
      chk(pix_src, {ZA[31:24], C1[23:0]});
      i_rccr_host.wr(IDX_MODE, 32'h0001_0602);
      ev(3, 5'h10);
      ev(2, 5'h08);
      ev(1, 5'h04);
      ev(1, 5'h02);
      @(posedge clk);
      pix_tex <= {8'h77, 24'h55_AA33};
      pix_valid <= 1'b1;
      @(posedge clk);
      pix_tex <= {8'h77, 24'h55_AA34};
      #1;
      chk(32'(key_drop), 32'h0000_0001);
      @(posedge clk);
      pix_valid <= 1'b0;
      #1;
      chk(32'(key_drop), 32'h0000_0000);
      chk(32'(bias_depth), 32'(ZA[15:0]));
      rdchk(IDX_PIN, 32'h0000_0003);
      rdchk(IDX_TFAIL, 32'h0000_0001);
      rdchk(IDX_ZFAIL, 32'h0000_0002);
      rdchk(IDX_AFAIL, 32'h0000_0001);
      rdchk(IDX_POUT, 32'h0000_0001);
      i_rccr_host.wr(IDX_FLUSH, 32'h0000_0000);
      #1;
      chk(32'(pipe_flush), 32'h0000_0001);
      rdchk(IDX_PIN, 32'h0000_0003);
      i_rccr_host.wr(IDX_FLUSH, 32'h0000_0001);
      for (int i = 9; i < 14; i++) rdchk(8'(i), 32'h0000_0000);
      i_rccr_host.wr(IDX_VB, 32'h0001_0003);
      fill(32'h0000_0600, 32'h0002_0004, 4);
      fill(32'h0000_0200, 32'h0002_0004, 4);
      fill(32'h0000_0600, 32'h0004_0004, 0);
      rdchk(IDX_POUT, 32'h0000_0008);
      fill(32'h0000_0700, 32'h0002_0004, 4);
      for (int k = 0; k < 2; k++) begin
         i_rccr_host.wr(IDX_SWAP, 32'h0000_0003);
         i_rccr_host.rd(IDX_PEND, rd_v);
         chk(32'(rd_v[30:28]), 32'h0000_0001);
         ev(1, 5'h01);
         sw(3, c);
         chk(32'(c), 32'h0000_0000);
         ev(1, 5'h01);
         sw(3, c);
         chk(32'(c), 32'h0000_0001);
         i_rccr_host.rd(IDX_PEND, rd_v);
         chk(32'(rd_v[30:28]), 32'h0000_0000);
      end
      i_rccr_host.wr(IDX_SWAP, 32'h0000_000A);
      sw(3, c);
      chk(32'(c), 32'h0000_0001);
      i_rccr_host.wr(IDX_SWAP, 32'h0000_0001);
      sw(2, c);
      chk(32'(c), 32'h0000_0000);
      ev(1, 5'h01);
      sw(3, c);
      chk(32'(c), 32'h0000_0001);
      test_done();
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
